/* design/hbga_cfg.svh */
// Constants for the host bus grant and asynchronous access port.
`ifndef HBGA_CFG_SVH
`define HBGA_CFG_SVH
`define HBGA_ADDR_W 24
`define HBGA_DATA_W 32
`define HBGA_REG_IDX_W 4
`define HBGA_REG_NUM 16
// The upper address line that marks the multiprocessor memory space.
`define HBGA_MMS_BIT 23
// Low pulse of the ready line on a read, least time in ns: 28.0 + DT, DT taken as zero.
`define HBGA_RDY_RD_NS 28
`define HBGA_RDY_RD_CYC ((`HBGA_RDY_RD_NS + 4) / 5)
// Low pulse of the ready line on a write, least time in ps (7.75 ns).
`define HBGA_RDY_WR_PS 7750
`define HBGA_RDY_WR_CYC ((`HBGA_RDY_WR_PS + 4999) / 5000)
`define HBGA_CNT_W 4
`define HBGA_DATA_RST 32'h0000_0000
`endif

/* design/hbga_pkg.sv */
// Types for the host bus grant and asynchronous access port.
package hbga_pkg;
    typedef enum logic [3:0] {
        HBGA_OWN = 4'h1,
        HBGA_DRAIN = 4'h2,
        HBGA_GRANT = 4'h4,
        HBGA_RETURN = 4'h8
    } hbga_arb_e;
    typedef enum logic [2:0] {
        HBGA_IDLE = 3'h1,
        HBGA_WAIT = 3'h2,
        HBGA_DONE = 3'h4
    } hbga_acc_e;
endpackage

/* design/hbga_sync_req.sv */
// Synchroniser for the request inputs and fast release of priority access.
`timescale 1ns/1ps
`include "hbga_cfg.svh"
module hbga_sync_req (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic host_bus_request_n_i,
    input wire logic processor_bus_request_n_i,
    input wire logic core_priority_access_n_i,
    output logic host_req_o,
    output logic proc_req_o,
    output logic prio_o
);
    logic [2:0] stage1;
    logic [2:0] stage2;
    logic [2:0] next_stage1;
    logic [2:0] next_stage2;

    always_comb
    begin
        next_stage1 = {~core_priority_access_n_i, ~processor_bus_request_n_i, ~host_bus_request_n_i};
        next_stage2 = stage1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stage1 <= 3'h0;
            stage2 <= 3'h0;
        end
        else
        begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    // A request seen only after a late edge is simply taken one clock later.
    assign host_req_o = stage2[0];
    assign proc_req_o = stage2[1];
    // Assertion is clocked; release is taken at once from the pin.
    assign prio_o = stage2[2] & ~core_priority_access_n_i;
endmodule

/* design/hbga_host_port.sv */
// Host bus grant arbitration and asynchronous register access port.
`timescale 1ns/1ps
`include "hbga_cfg.svh"
module hbga_host_port (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic host_bus_request_n_i,
    input wire logic host_select_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [`HBGA_ADDR_W-1:0] host_addr_i,
    input wire logic [`HBGA_DATA_W-1:0] host_wdata_i,
    input wire logic processor_bus_request_n_i,
    input wire logic core_priority_access_n_i,
    input wire logic ready_open_drain_i,
    input wire logic core_cycle_busy_i,
    output logic host_bus_grant_n_o,
    output logic host_ready_out_o,
    output logic host_ready_out_oe_n_o,
    output logic [`HBGA_DATA_W-1:0] host_rdata_o,
    output logic host_rdata_oe_n_o,
    output logic mem_if_oe_n_o,
    output logic host_req_seen_o,
    output logic proc_req_seen_o,
    output logic prio_access_o,
    output logic mms_access_o
);
    logic host_req;
    logic [`HBGA_DATA_W-1:0] regs [`HBGA_REG_NUM];
    hbga_pkg::hbga_arb_e arb;
    hbga_pkg::hbga_arb_e next_arb;
    hbga_pkg::hbga_acc_e acc;
    hbga_pkg::hbga_acc_e next_acc;
    logic [`HBGA_CNT_W-1:0] cnt;
    logic [`HBGA_CNT_W-1:0] next_cnt;
    logic acc_rd;
    logic next_acc_rd;
    logic [`HBGA_DATA_W-1:0] rdata;
    logic [`HBGA_DATA_W-1:0] next_rdata;
    logic granted;
    logic rd_low;
    logic wr_low;
    logic [`HBGA_REG_IDX_W-1:0] idx;
    logic strobe_ok;

    function automatic logic is_mms(input logic [`HBGA_ADDR_W-1:0] a);
        is_mms = ~a[`HBGA_MMS_BIT];
    endfunction

    hbga_sync_req u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .host_bus_request_n_i(host_bus_request_n_i),
        .processor_bus_request_n_i(processor_bus_request_n_i),
        .core_priority_access_n_i(core_priority_access_n_i),
        .host_req_o(host_req),
        .proc_req_o(proc_req_seen_o),
        .prio_o(prio_access_o)
    );
    assign host_req_seen_o = host_req;

    ////////////////////////////////////////////////////////////////////////////
    // Bus hand-over.

    always_comb
    begin
        next_arb = arb;
        unique case (arb)
            hbga_pkg::HBGA_OWN:
                if (host_req)
                    next_arb = hbga_pkg::HBGA_DRAIN;
            hbga_pkg::HBGA_DRAIN:
                // Wait for the own cycle to end; the interface is already floated.
                if (!host_req)
                    next_arb = hbga_pkg::HBGA_OWN;
                else if (!core_cycle_busy_i)
                    next_arb = hbga_pkg::HBGA_GRANT;
            hbga_pkg::HBGA_GRANT:
                // Grant holds while the request holds.
                if (!host_req)
                    next_arb = hbga_pkg::HBGA_RETURN;
            hbga_pkg::HBGA_RETURN:
                next_arb = hbga_pkg::HBGA_OWN;
            default:
                next_arb = hbga_pkg::HBGA_OWN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            arb <= hbga_pkg::HBGA_OWN;
        else
            arb <= next_arb;
    end

    assign granted = (arb == hbga_pkg::HBGA_GRANT);
    assign host_bus_grant_n_o = ~granted;
    // Interface resumes one clock after grant drops, on leaving the return state.
    assign mem_if_oe_n_o = (arb != hbga_pkg::HBGA_OWN);

    ////////////////////////////////////////////////////////////////////////////
    // Asynchronous register access.

    // Strobes count only under grant with select low.
    assign rd_low = granted & ~host_select_n_i & ~host_rd_n_i;
    assign wr_low = granted & ~host_select_n_i & ~host_wr_n_i;
    assign idx = host_addr_i[`HBGA_REG_IDX_W-1:0];
    assign mms_access_o = granted & (rd_low | wr_low) & is_mms(host_addr_i);
    // A strobe into the multiprocessor space is refused outright: nothing is stored and no wait is raised.
    assign strobe_ok = (rd_low | wr_low) & ~is_mms(host_addr_i);

    always_comb
    begin
        next_acc = acc;
        next_cnt = cnt;
        next_acc_rd = acc_rd;
        next_rdata = rdata;
        unique case (acc)
            hbga_pkg::HBGA_IDLE:
                // The count is loaded at the first edge that sees the strobe, so the full count follows it.
                if (strobe_ok)
                begin
                    next_acc = hbga_pkg::HBGA_WAIT;
                    next_acc_rd = rd_low;
                    next_cnt = rd_low ? `HBGA_CNT_W'(`HBGA_RDY_RD_CYC) : `HBGA_CNT_W'(`HBGA_RDY_WR_CYC);
                end
            hbga_pkg::HBGA_WAIT:
            begin
                next_cnt = cnt - `HBGA_CNT_W'(1);
                if (acc_rd)
                    next_rdata = regs[idx];
                // Data is latched on each clock of the wait, the last time at the edge where ready leaves its low state.
                if (cnt == `HBGA_CNT_W'(1))
                    next_acc = hbga_pkg::HBGA_DONE;
            end
            hbga_pkg::HBGA_DONE:
                // Host holds its strobe until ready releases.
                if (host_rd_n_i && host_wr_n_i)
                    next_acc = hbga_pkg::HBGA_IDLE;
            default:
                next_acc = hbga_pkg::HBGA_IDLE;
        endcase
        // Losing the grant abandons any access, so a stale wait cannot reach the next hand-over.
        if (!granted)
            next_acc = hbga_pkg::HBGA_IDLE;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc <= hbga_pkg::HBGA_IDLE;
            cnt <= `HBGA_CNT_W'(0);
            acc_rd <= 1'b0;
            rdata <= `HBGA_DATA_RST;
        end
        else
        begin
            acc <= next_acc;
            cnt <= next_cnt;
            acc_rd <= next_acc_rd;
            rdata <= next_rdata;
        end
    end

    // The register file has no reset; a register reads as unknown until it is first written.
    // Each clock with the strobe low stores the data, so writes as close as one clock are all taken.
    always_ff @(posedge clk_sys_i)
    begin
        if (wr_low && !is_mms(host_addr_i))
            regs[idx] <= host_wdata_i;
    end

    assign host_rdata_o = rdata;
    assign host_rdata_oe_n_o = ~(granted & ~host_select_n_i & acc_rd & (acc != hbga_pkg::HBGA_IDLE));

    ////////////////////////////////////////////////////////////////////////////
    // Ready pin; the strobe falling pulls it low at once, ahead of the state update.

    logic rdy_low;
    logic rdy_drive;
    logic rdy_pregrant;
    logic rdy_strobe;
    logic rdy_wait;
    always_comb
    begin
        // Low before grant with select and request low.
        rdy_pregrant = ~host_select_n_i & ~host_bus_request_n_i & ~granted;
        // Low from the strobe or select fall until the pulse ends.
        // A refused access must not pull ready low, or the host would wait on a pulse that never ends.
        rdy_strobe = (acc == hbga_pkg::HBGA_IDLE) & strobe_ok;
        rdy_wait = (acc == hbga_pkg::HBGA_WAIT);
        rdy_low = rdy_pregrant | rdy_strobe | rdy_wait;
        // Active drive stops when select or request rises.
        rdy_drive = rdy_low | (~ready_open_drain_i & granted & ~host_select_n_i & ~host_bus_request_n_i);
        // Open drain floats when not low; active drive drives high after grant.
        host_ready_out_o = ~rdy_low;
        host_ready_out_oe_n_o = ~rdy_drive;
    end
endmodule

/* bench/hbga_host_port_assertions.sv */
// Concurrent checks on the ports of the host bus grant port.
`timescale 1ns/1ps
module hbga_chk (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic host_bus_request_n_i,
    input wire logic host_select_n_i,
    input wire logic host_rd_n_i,
    input wire logic core_priority_access_n_i,
    input wire logic ready_open_drain_i,
    input wire logic core_cycle_busy_i,
    input wire logic host_bus_grant_n_o,
    input wire logic host_ready_out_o,
    input wire logic host_ready_out_oe_n_o,
    input wire logic mem_if_oe_n_o,
    input wire logic prio_access_o,
    input wire logic host_rdata_oe_n_o,
    input wire logic mms_access_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    // The pull-up takes an undriven ready pin high, so judge the pin level.
    wire rdy = host_ready_out_oe_n_o | host_ready_out_o;
    sequence s_read_start;
        $fell(host_rd_n_i) && !host_bus_grant_n_o && !host_select_n_i;
    endsequence
    sequence s_prio_held;
        $fell(core_priority_access_n_i) ##1 !core_priority_access_n_i [*2];
    endsequence
    a_wait_pregrant: assert property (
        !host_select_n_i && !host_bus_request_n_i && host_bus_grant_n_o |-> !rdy) else $error("ready not low");
    a_ready_granted: assert property (
        $fell(host_bus_grant_n_o) |-> ##[0:16] (rdy && host_ready_out_oe_n_o == ready_open_drain_i))
        else $error("ready not released after grant");
    a_active_release: assert property (
        !ready_open_drain_i && (host_select_n_i || host_bus_request_n_i) |-> host_ready_out_oe_n_o)
        else $error("ready still driven");
    a_od_never_high: assert property (ready_open_drain_i && !host_ready_out_oe_n_o |-> !host_ready_out_o)
        else $error("open drain ready driven high");
    a_read_pulse: assert property (s_read_start |-> !rdy [*5] ##[1:4] rdy)
        else $error("read wait pulse wrong");
    a_grant_idle: assert property ($fell(host_bus_grant_n_o) |-> !$past(core_cycle_busy_i))
        else $error("grant during own cycle");
    a_mem_float: assert property (!host_bus_grant_n_o |-> mem_if_oe_n_o)
        else $error("memory interface driven under grant");
    a_prio_sync: assert property (s_prio_held |-> prio_access_o)
        else $error("priority access not seen");
    a_rdata_driven: assert property (s_read_start |=> !host_rdata_oe_n_o [*5])
        else $error("read data not driven during wait");
    a_mms_no_wait: assert property (mms_access_o |-> rdy)
        else $error("refused access raised a wait");
endmodule
bind hbga_host_port hbga_chk hbga_chk_inst (.clk_sys_i, .rst_n_i, .host_bus_request_n_i, .host_select_n_i, .host_rd_n_i,
    .core_priority_access_n_i, .ready_open_drain_i, .core_cycle_busy_i, .host_bus_grant_n_o, .host_ready_out_o,
    .host_ready_out_oe_n_o, .mem_if_oe_n_o, .prio_access_o, .host_rdata_oe_n_o, .mms_access_o);

/* bench/hbga_host_model.sv */
// Behavioural host processor that borrows the bus and accesses registers.
`timescale 1ns/1ps
`include "hbga_cfg.svh"
module hbga_host_model (
    input wire logic clk_sys_i,
    input wire logic ready_i,
    input wire logic [`HBGA_DATA_W-1:0] rdata_i,
    output logic req_n_o,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [`HBGA_ADDR_W-1:0] addr_o,
    output logic [`HBGA_DATA_W-1:0] wdata_o
);
    initial {req_n_o, cs_n_o, rd_n_o, wr_n_o, addr_o, wdata_o} = {4'hf, 56'h0};
    task automatic claim(input logic on);
        @(negedge clk_sys_i);
        req_n_o = !on;
        cs_n_o = !on;
        addr_o[`HBGA_MMS_BIT] = 1'b1;
    endtask
    // Two falling edges between strobes keep the high width above one clock.
    task automatic access(input logic wr, input logic [`HBGA_ADDR_W-1:0] a, input logic [`HBGA_DATA_W-1:0] d,
        output logic [`HBGA_DATA_W-1:0] q);
        int n;
        repeat (2) @(negedge clk_sys_i);
        addr_o = a;
        wdata_o = d;
        rd_n_o = wr;
        wr_n_o = !wr;
        // Ready is judged at falling edges, where it has settled; it then stands through the next rising edge.
        n = 0;
        do
        begin
            @(negedge clk_sys_i);
            n++;
        end
        while (ready_i !== 1'b1 && n < 20);
        q = rdata_i;
        @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
    endtask
endmodule

/* bench/testbench.sv */
// Self-checking bench for the host bus grant port.
`timescale 1ns/1ps
`include "hbga_cfg.svh"
module testbench;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic core_priority_access_n_i = 1'b1;
    logic processor_bus_request_n_i = 1'b1;
    logic ready_open_drain_i = 1'b1;
    logic core_cycle_busy_i = 1'b0;
    logic host_bus_request_n_i, host_select_n_i, host_rd_n_i, host_wr_n_i, host_bus_grant_n_o, host_ready_out_o;
    logic host_ready_out_oe_n_o, mem_if_oe_n_o, host_req_seen_o, proc_req_seen_o, prio_access_o;
    logic [`HBGA_ADDR_W-1:0] host_addr_i;
    logic [`HBGA_DATA_W-1:0] host_wdata_i, host_rdata_o, q;
    int fails = 0;
    int num_checks = 0;
    wire rdy = host_ready_out_oe_n_o ? 1'b1 : host_ready_out_o;
    always #2.5 clk_sys_i = ~clk_sys_i;
    hbga_host_port hbga_host_port_inst (.clk_sys_i, .rst_n_i, .host_bus_request_n_i, .host_select_n_i, .host_rd_n_i,
        .host_wr_n_i, .host_addr_i, .host_wdata_i, .processor_bus_request_n_i, .core_priority_access_n_i,
        .ready_open_drain_i, .core_cycle_busy_i, .host_bus_grant_n_o, .host_ready_out_o, .host_ready_out_oe_n_o,
        .host_rdata_o, .host_rdata_oe_n_o(), .mem_if_oe_n_o, .host_req_seen_o, .proc_req_seen_o, .prio_access_o,
        .mms_access_o());
    hbga_host_model hbga_host_model_inst (.clk_sys_i, .ready_i(rdy), .rdata_i(host_rdata_o),
        .req_n_o(host_bus_request_n_i), .cs_n_o(host_select_n_i), .rd_n_o(host_rd_n_i), .wr_n_o(host_wr_n_i),
        .addr_o(host_addr_i), .wdata_o(host_wdata_i));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic test_prio();
        @(negedge clk_sys_i);
        core_priority_access_n_i = 1'b0;
        processor_bus_request_n_i = 1'b0;
        @(negedge clk_sys_i);
        check("prio early", 0, prio_access_o);
        check("proc req early", 0, proc_req_seen_o);
        @(negedge clk_sys_i);
        check("prio", 1, prio_access_o);
        check("proc req", 1, proc_req_seen_o);
        @(negedge clk_sys_i);
        check("prio held", 1, prio_access_o);
        core_priority_access_n_i = 1'b1;
        processor_bus_request_n_i = 1'b1;
        #1;
        check("prio release", 0, prio_access_o);
        $display("test_prio done");
    endtask
    // The core is kept busy first, so an early grant would show.
    task automatic test_grant(input logic od);
        ready_open_drain_i = od;
        core_cycle_busy_i = 1'b1;
        hbga_host_model_inst.claim(1'b1);
        #1;
        check("ready pregrant", 0, rdy);
        repeat (8) @(negedge clk_sys_i);
        check("req seen", 1, host_req_seen_o);
        check("grant busy", 1, host_bus_grant_n_o);
        check("mem_if float", 1, mem_if_oe_n_o);
        core_cycle_busy_i = 1'b0;
        for (int n = 0; n < 10 && host_bus_grant_n_o !== 1'b0; n++)
            @(negedge clk_sys_i);
        check("grant", 0, host_bus_grant_n_o);
        repeat (12) @(negedge clk_sys_i);
        check("ready oe_n", od, host_ready_out_oe_n_o);
        check("ready pin", 1, rdy);
        $display("test_grant done");
    endtask
    task automatic test_access(input logic [27:0] base);
        for (int i = 0; i < 3; i++)
            hbga_host_model_inst.access(1'b1, {20'h80000, i[3:0]}, {base, i[3:0]}, q);
        hbga_host_model_inst.access(1'b1, 24'h000001, 32'hdead_beef, q);
        for (int i = 0; i < 3; i++)
        begin
            hbga_host_model_inst.access(1'b0, {20'h80000, i[3:0]}, 32'h0, q);
            check("read data", {base, i[3:0]}, q);
        end
        $display("test_access done");
    endtask
    task automatic test_release();
        hbga_host_model_inst.claim(1'b0);
        #1;
        check("ready undriven", 1, host_ready_out_oe_n_o);
        repeat (6) @(negedge clk_sys_i);
        check("grant off", 1, host_bus_grant_n_o);
        check("mem_if driven", 0, mem_if_oe_n_o);
        $display("test_release done");
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        test_prio();
        test_grant(1'b1);
        test_access(28'ha5a5000);
        test_release();
        test_grant(1'b0);
        test_access(28'h3c3c000);
        test_release();
        tally_and_finish();
    end
    initial
    begin
        #20000;
        fails++;
        tally_and_finish();
    end
endmodule
